/* File: rtl/ccim_pkg.sv */
package ccim_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [7:0] OFS_FUNC_SELECT  = 8'h00;
    localparam logic [7:0] OFS_FUNC_ENABLE  = 8'h04;
    localparam logic [7:0] OFS_ENABLE_MASK  = 8'h08;
    localparam logic [7:0] OFS_PENDING      = 8'h0C;
    localparam logic [7:0] OFS_COMBINED_IRQ = 8'h10;
    localparam logic [7:0] OFS_BASE_IRQ     = 8'h14;
    localparam logic [7:0] OFS_CTRL_BASE    = 8'h20;
    localparam logic [7:0] OFS_CMP_BASE     = 8'h40;
    localparam logic [7:0] OFS_BANK_MASK    = 8'hE0;

    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [12:0] RST_CTRL = 13'h0000;
    localparam logic [15:0] RST_CMP  = 16'h0000;

    // Interrupt control fields
    localparam int          FLAG_BIT  = 3;
    localparam int          LEVEL_MSB = 2;

    // Writable bits of a channel control word; soft clear reads zero
    localparam logic [12:0] CTRL_WMASK = 13'h1BF3;
    localparam int          GSC_BIT    = 10;

    // Operation field codes, waveform generation
    localparam logic [1:0] OP_SINGLE = 2'b00;
    localparam logic [1:0] OP_SR     = 2'b01;
    localparam logic [1:0] OP_PHASE  = 2'b10;

    // Operation field codes, time measurement
    localparam logic [1:0] EDGE_NONE = 2'b00;
    localparam logic [1:0] EDGE_RISE = 2'b01;
    localparam logic [1:0] EDGE_FALL = 2'b10;
    localparam logic [1:0] EDGE_BOTH = 2'b11;

    // Input filter codes
    localparam logic [1:0] FILT_OFF   = 2'b00;
    localparam logic [1:0] FILT_TIMER = 2'b10;
    localparam logic [1:0] FILT_SYS   = 2'b11;

    // Filter length in samples
    localparam int FILT_TAPS = 3;

    // Per-channel control word
    typedef struct packed {
        logic       output_flip;
        logic       reload_at_reset;
        logic       gate_soft_clear;
        logic       gate_clear_on_match;
        logic       gate_option;
        logic       count_divide_option;
        logic       output_start_level;
        logic [1:0] input_filter_select;
        logic [1:0] unused_bits;
        logic [1:0] operation_select;
    } ccim_chan_ctrl_type;

    // Interrupt control register content
    typedef struct packed {
        logic       request_flag;
        logic [2:0] priority_level;
    } ccim_irq_ctrl_type;

endpackage

/* File: rtl/ccim_irq_merge.sv */
`timescale 1ns/1ns
// How it works
// - Base reset or overflow sets base flag
// - Channel request sets its pending bit
// - Enable mask gates channel into combined interrupt
// - Enabled request sets pending and combined flag
// - CPU acceptance leaves pending bits set
// - Requests while pending is set are lost
// - Pending register readable to find channel
// - Waveform modes single, set-reset, phase-delayed
// - Measurement edges none, rising, falling, both
// - Filter off, timer-clock or system-clock sampling
// - Start level sets initial waveform output
// - Reload bit picks immediate or base-reset load
// - Gate cleared on paired match or soft
// - Flip bit inverts the waveform output
// - Divide option bit applies the prescaler
// - Select bit picks measurement or waveform
// - Enable bit activates channel function
// - Control holds level, flag bit 3
module ccim_irq_merge #(
    parameter int CHANNELS   = 8,
    parameter int PRESCALE_N = 2
) (
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        base_tick_i,
    input  wire logic        base_reset_i,
    input  wire logic        base_overflow_i,
    input  wire logic [15:0] base_count_i,
    input  wire logic [7:0]  capture_pin_i,
    input  wire logic        irq_accept_i,
    input  wire logic        base_accept_i,
    output logic      [7:0]  wave_o,
    output logic             combined_irq_o,
    output logic      [2:0]  combined_level_o,
    output logic             base_irq_o,
    output logic      [2:0]  base_level_o
);

    ccim_pkg::ccim_chan_ctrl_type ctrl_q [8];
    logic [15:0]                  shadow_q [8];
    logic [15:0]                  active_q [8];
    logic [ccim_pkg::FILT_TAPS-1:0] shift_q [8];
    logic [7:0]                   div_q [8];
    logic [7:0]                   fsel_q;
    logic [7:0]                   fen_q;
    logic [7:0]                   mask_q;
    logic [7:0]                   pend_q;
    logic [7:0]                   filt_q;
    logic [7:0]                   prev_q;
    logic [7:0]                   gate_shut_q;
    logic [7:0]                   wave_q;
    ccim_pkg::ccim_irq_ctrl_type  cirq_q;
    ccim_pkg::ccim_irq_ctrl_type  birq_q;
    logic                         req;
    logic                         wr;
    logic                         in_ctrl;
    logic                         in_cmp;
    logic [2:0]                   bank_idx;
    logic [7:0]                   match;
    logic [7:0]                   cap_hit;
    logic [7:0]                   raw_evt;
    logic [7:0]                   evt;
    logic [7:0]                   set_vec;
    logic [7:0]                   pend_clr;
    logic [7:0]                   soft_clr;
    logic [31:0]                  rd_d;

    // Byte-lane merge of one 8-bit field
    function automatic logic [7:0] merge8(input logic [7:0] old_v, input logic [7:0] new_v,
                                          input logic lane);
        merge8 = lane ? new_v : old_v;
    endfunction

    // Sample strobe chosen by the filter field
    function automatic logic sample_en(input logic [1:0] sel, input logic tick);
        unique case (sel)
            ccim_pkg::FILT_TIMER: sample_en = tick;
            ccim_pkg::FILT_SYS:   sample_en = 1'b1;
            default:              sample_en = 1'b0;
        endcase
    endfunction

    // Bus decode: one request per transfer, answered next cycle
    assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr       = req && wb_we_i;
    assign bank_idx = wb_adr_i[4:2];
    assign in_ctrl  = (wb_adr_i & ccim_pkg::OFS_BANK_MASK) == ccim_pkg::OFS_CTRL_BASE;
    assign in_cmp   = (wb_adr_i & ccim_pkg::OFS_BANK_MASK) == ccim_pkg::OFS_CMP_BASE;

    // Channel event generation
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            match[i] = base_count_i == active_q[i];
            unique case (ctrl_q[i].operation_select)
                ccim_pkg::EDGE_RISE: cap_hit[i] = filt_q[i] && !prev_q[i];
                ccim_pkg::EDGE_FALL: cap_hit[i] = !filt_q[i] && prev_q[i];
                ccim_pkg::EDGE_BOTH: cap_hit[i] = filt_q[i] != prev_q[i];
                default:             cap_hit[i] = 1'b0;
            endcase
            if (fsel_q[i]) begin
                raw_evt[i] = cap_hit[i] && !(ctrl_q[i].gate_option && gate_shut_q[i]);
            end else begin
                raw_evt[i] = match[i];
            end
            raw_evt[i] = raw_evt[i] && fen_q[i];
            evt[i]     = raw_evt[i] && (!ctrl_q[i].count_divide_option ||
                         div_q[i] == 8'(PRESCALE_N - 1));
            soft_clr[i] = wr && in_ctrl && bank_idx == 3'(i) && wb_sel_i[1] &&
                          wb_dat_i[ccim_pkg::GSC_BIT];
        end
        set_vec  = evt & ~pend_q;
        pend_clr = (wr && wb_adr_i == ccim_pkg::OFS_PENDING && wb_sel_i[0]) ?
                   ~wb_dat_i[7:0] : 8'h00;
    end

    // Input filter: level accepted after equal samples
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (reset_i) begin
                shift_q[i] <= '0;
                filt_q[i]  <= 1'b0;
                prev_q[i]  <= 1'b0;
            end else begin
                prev_q[i] <= filt_q[i];
                if (sample_en(ctrl_q[i].input_filter_select, base_tick_i)) begin
                    shift_q[i] <= {shift_q[i][ccim_pkg::FILT_TAPS-2:0], capture_pin_i[i]};
                end
                if (ctrl_q[i].input_filter_select == ccim_pkg::FILT_OFF) begin
                    filt_q[i] <= capture_pin_i[i];
                end else if (&shift_q[i] || ~|shift_q[i]) begin
                    filt_q[i] <= shift_q[i][0];
                end
            end
        end
    end

    // Prescaler counters
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (reset_i || !ctrl_q[i].count_divide_option) begin
                div_q[i] <= 8'h00;
            end else if (raw_evt[i]) begin
                div_q[i] <= (div_q[i] == 8'(PRESCALE_N - 1)) ? 8'h00 : div_q[i] + 8'h01;
            end
        end
    end

    // Capture gate: shut by a capture, reopened by match or soft clear
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (reset_i) begin
                gate_shut_q[i] <= 1'b0;
            end else if (soft_clr[i] ||
                         (ctrl_q[i].gate_clear_on_match && match[i ^ 1])) begin
                gate_shut_q[i] <= 1'b0;
            end else if (raw_evt[i] && fsel_q[i] && ctrl_q[i].gate_option) begin
                gate_shut_q[i] <= 1'b1;
            end
        end
    end

    // Waveform generation per channel
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (reset_i) begin
                wave_q[i] <= 1'b0;
            end else if (!fen_q[i] || fsel_q[i] || base_reset_i) begin
                wave_q[i] <= ctrl_q[i].output_start_level;
            end else begin
                unique case (ctrl_q[i].operation_select)
                    ccim_pkg::OP_SINGLE: if (match[i]) wave_q[i] <= !ctrl_q[i].output_start_level;
                    ccim_pkg::OP_SR: begin
                        if (match[i]) begin
                            wave_q[i] <= !ctrl_q[i].output_start_level;
                        end else if (match[i ^ 1]) begin
                            wave_q[i] <= ctrl_q[i].output_start_level;
                        end
                    end
                    ccim_pkg::OP_PHASE: if (match[i]) wave_q[i] <= !wave_q[i];
                    default: wave_q[i] <= wave_q[i];
                endcase
            end
        end
    end

    // Output stage with inversion
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (reset_i) begin
                wave_o[i] <= 1'b0;
            end else begin
                wave_o[i] <= wave_q[i] ^ ctrl_q[i].output_flip;
            end
        end
    end

    // Channel control and compare registers
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (reset_i) begin
                ctrl_q[i]   <= ccim_pkg::RST_CTRL;
                shadow_q[i] <= ccim_pkg::RST_CMP;
                active_q[i] <= ccim_pkg::RST_CMP;
            end else begin
                if (wr && in_ctrl && bank_idx == 3'(i)) begin
                    ctrl_q[i] <= {wb_sel_i[1] ? wb_dat_i[12:8] : ctrl_q[i][12:8],
                                  merge8(ctrl_q[i][7:0], wb_dat_i[7:0], wb_sel_i[0])} &
                                 ccim_pkg::CTRL_WMASK;
                end
                if (wr && in_cmp && bank_idx == 3'(i)) begin
                    shadow_q[i] <= {merge8(shadow_q[i][15:8], wb_dat_i[15:8], wb_sel_i[1]),
                                    merge8(shadow_q[i][7:0], wb_dat_i[7:0], wb_sel_i[0])};
                    if (!ctrl_q[i].reload_at_reset) begin
                        active_q[i] <= {merge8(shadow_q[i][15:8], wb_dat_i[15:8], wb_sel_i[1]),
                                        merge8(shadow_q[i][7:0], wb_dat_i[7:0], wb_sel_i[0])};
                    end
                end else if (base_reset_i && ctrl_q[i].reload_at_reset) begin
                    active_q[i] <= shadow_q[i];
                end
            end
        end
    end

    // Function select, enable and mask registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            fsel_q <= ccim_pkg::RST_BYTE;
            fen_q  <= ccim_pkg::RST_BYTE;
            mask_q <= ccim_pkg::RST_BYTE;
        end else if (wr) begin
            if (wb_adr_i == ccim_pkg::OFS_FUNC_SELECT) fsel_q <= merge8(fsel_q, wb_dat_i[7:0], wb_sel_i[0]);
            if (wb_adr_i == ccim_pkg::OFS_FUNC_ENABLE) fen_q  <= merge8(fen_q, wb_dat_i[7:0], wb_sel_i[0]);
            if (wb_adr_i == ccim_pkg::OFS_ENABLE_MASK) mask_q <= merge8(mask_q, wb_dat_i[7:0], wb_sel_i[0]);
        end
    end

    // Pending bits: sticky, set wins over a zero write
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            pend_q <= ccim_pkg::RST_BYTE;
        end else begin
            pend_q <= (pend_q & ~pend_clr) | evt;
        end
    end

    // Combined interrupt control: level and request flag
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cirq_q <= '0;
        end else begin
            if (wr && wb_adr_i == ccim_pkg::OFS_COMBINED_IRQ && wb_sel_i[0]) begin
                cirq_q <= wb_dat_i[3:0];
            end else if (irq_accept_i) begin
                cirq_q.request_flag <= 1'b0;
            end
            if (|(set_vec & mask_q)) begin
                cirq_q.request_flag <= 1'b1;
            end
        end
    end

    // Base timer interrupt control
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            birq_q <= '0;
        end else begin
            if (wr && wb_adr_i == ccim_pkg::OFS_BASE_IRQ && wb_sel_i[0]) begin
                birq_q <= wb_dat_i[3:0];
            end else if (base_accept_i) begin
                birq_q.request_flag <= 1'b0;
            end
            if (base_reset_i || base_overflow_i) begin
                birq_q.request_flag <= 1'b1;
            end
        end
    end

    // Interrupt outputs
    assign combined_irq_o   = cirq_q.request_flag;
    assign combined_level_o = cirq_q.priority_level;
    assign base_irq_o       = birq_q.request_flag;
    assign base_level_o     = birq_q.priority_level;

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_d = 32'h0000_0000;
        if (in_ctrl) begin
            rd_d[12:0] = ctrl_q[bank_idx];
        end else if (in_cmp) begin
            rd_d[15:0] = shadow_q[bank_idx];
        end else begin
            unique case (wb_adr_i)
                ccim_pkg::OFS_FUNC_SELECT:  rd_d[7:0] = fsel_q;
                ccim_pkg::OFS_FUNC_ENABLE:  rd_d[7:0] = fen_q;
                ccim_pkg::OFS_ENABLE_MASK:  rd_d[7:0] = mask_q;
                ccim_pkg::OFS_PENDING:      rd_d[7:0] = pend_q;
                ccim_pkg::OFS_COMBINED_IRQ: rd_d[3:0] = cirq_q;
                ccim_pkg::OFS_BASE_IRQ:     rd_d[3:0] = birq_q;
                default:                    rd_d = 32'h0000_0000;
            endcase
        end
    end

    // Wishbone answer: ack one cycle after the request
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_d : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    a_base_flag_set: assert property ((base_reset_i || base_overflow_i) |=> base_irq_o)
        else $error("base flag not set after base event");
    a_pending_set: assert property ((|evt) |=> ((pend_q & $past(evt)) == $past(evt)))
        else $error("pending bit missing after channel event");
    a_mask_blocks: assert property ((!combined_irq_o && (set_vec & mask_q) == 8'h00 && !wr)
        |=> !combined_irq_o)
        else $error("masked channel raised combined flag");
    a_combined_set: assert property ((|(set_vec & mask_q)) |=> combined_irq_o ##0
        ((pend_q & $past(set_vec & mask_q)) != 8'h00))
        else $error("enabled request did not set combined flag");
    a_pending_kept: assert property ((irq_accept_i && pend_clr == 8'h00)
        |=> ((($past(pend_q)) & ~pend_q) == 8'h00))
        else $error("pending bit dropped on acceptance");
    a_full_pending_quiet: assert property ((&pend_q && !combined_irq_o && !wr)
        |=> !combined_irq_o)
        else $error("event while pending produced new request");
    a_reload_deferred: assert property ((wr && in_cmp && bank_idx == 3'd0 &&
        ctrl_q[0].reload_at_reset && !base_reset_i) |=> $stable(active_q[0]))
        else $error("deferred compare value loaded early");
    a_idle_start_level: assert property ((!fen_q[0] && $stable(ctrl_q[0])) [*2]
        |=> wave_o[0] == ($past(ctrl_q[0].output_start_level, 2) ^ $past(ctrl_q[0].output_flip, 2)))
        else $error("idle output not at start level");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_answer: assert property (req |=> wb_ack_o)
        else $error("request not answered next cycle");

    // Flag lifetime and pending read-back
    a_accept_clears: assert property ((irq_accept_i && !wr && (set_vec & mask_q) == 8'h00)
        |=> !combined_irq_o)
        else $error("accepted flag not cleared");
    a_base_keep: assert property ((base_irq_o && !base_accept_i && !wr) |=> base_irq_o)
        else $error("base flag dropped without clear");
    a_pending_read: assert property ((req && !wb_we_i && wb_adr_i == ccim_pkg::OFS_PENDING)
        |=> wb_dat_o[7:0] == $past(pend_q))
        else $error("pending register read wrong");

endmodule

/* File: tb/ccim_cpu_model.sv */
`timescale 1ns/1ns
// Interrupt handler side: accepts each raised flag after a short response delay
module ccim_cpu_model #(
    parameter int DELAY = 2
) (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic auto_i,
    input  wire logic irq_i,
    input  wire logic base_irq_i,
    output logic      accept_o,
    output logic      base_accept_o
);
    int wait_q;
    int base_wait_q;

    // Acceptance pulse only clears the flag, pending bits stay to software
    always_ff @(posedge clk_i) begin
        if (reset_i || !auto_i) begin
            wait_q   <= 0;
            accept_o <= 1'b0;
        end else begin
            wait_q   <= (irq_i && !accept_o && wait_q < DELAY) ? wait_q + 1 : 0;
            accept_o <= irq_i && !accept_o && wait_q == DELAY;
        end
    end

    // Same handling for the base timer flag
    always_ff @(posedge clk_i) begin
        if (reset_i || !auto_i) begin
            base_wait_q   <= 0;
            base_accept_o <= 1'b0;
        end else begin
            base_wait_q   <= (base_irq_i && !base_accept_o && base_wait_q < DELAY) ?
                             base_wait_q + 1 : 0;
            base_accept_o <= base_irq_i && !base_accept_o && base_wait_q == DELAY;
        end
    end
endmodule

/* File: tb/capture_compare_irq_merge_tb.sv */
`timescale 1ns/1ns
module capture_compare_irq_merge_tb;
    typedef struct packed {
        logic [7:0]  adr;
        logic [31:0] wr;
        logic [31:0] rd;
    } ccim_row_type;

    logic        clk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat;
    logic        ack;
    logic        tick = 1'b0;
    logic        breset = 1'b0;
    logic        bovf = 1'b0;
    logic [15:0] count = 16'h0000;
    logic [7:0]  pin = 8'h00;
    logic        auto = 1'b0;
    logic        accept;
    logic        base_accept;
    logic [7:0]  wave;
    logic        irq;
    logic [2:0]  level;
    logic        birq;
    logic [2:0]  blevel;
    logic [31:0] q;
    logic        r;
    int          error_cnt = 0;
    int          cmp_count = 0;
    // Write value, expected read-back
    ccim_row_type rows [8] = '{
        '{8'h00, 32'h0000_005A, 32'h0000_005A}, '{8'h08, 32'h0000_00C3, 32'h0000_00C3},
        '{8'h20, 32'h0000_1FFF, 32'h0000_1BF3}, '{8'h44, 32'h0000_1234, 32'h0000_1234},
        '{8'h10, 32'h0000_00F5, 32'h0000_0005}, '{8'h14, 32'h0000_0006, 32'h0000_0006},
        '{8'h18, 32'h0000_00FF, 32'h0000_0000}, '{8'h0C, 32'h0000_00FF, 32'h0000_0000}};

    ccim_irq_merge i_ccim_irq_merge (
        .clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .base_tick_i(tick), .base_reset_i(breset), .base_overflow_i(bovf),
        .base_count_i(count), .capture_pin_i(pin), .irq_accept_i(accept),
        .base_accept_i(base_accept), .wave_o(wave), .combined_irq_o(irq),
        .combined_level_o(level), .base_irq_o(birq), .base_level_o(blevel));

    ccim_cpu_model i_ccim_cpu_model (
        .clk_i(clk_i), .reset_i(reset_i), .auto_i(auto), .irq_i(irq), .base_irq_i(birq),
        .accept_o(accept), .base_accept_o(base_accept));

    // Clock and timer sample strobe
    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) tick <= ~tick;

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // Wishbone classic single cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'h3;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        if (ack !== 1'b1) error_cnt++;
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    // One-cycle base count equal to the compare value
    task automatic match();
        @(posedge clk_i);
        count <= 16'h0100;
        @(posedge clk_i);
        count <= 16'h0000;
        #1;
    endtask

    // Bounded wait for both flags to drop
    task automatic wait_low();
        int n;
        n = 0;
        while ((irq !== 1'b0 || birq !== 1'b0) && n < 20) begin
            n++;
            @(posedge clk_i);
        end
        #1;
    endtask

    task automatic end_of_test();
        $display("Compares %0d, errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (8000) @(posedge clk_i);
        error_cnt++;
        end_of_test();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        // Reset values of the main registers
        for (int i = 0; i < 6; i++) begin
            wb(1'b0, 8'(i * 4), 32'h0000_0000);
            chk(32'h0000_0000, q);
        end
        // Table of write and read-back cases
        foreach (rows[i]) begin
            wb(1'b1, rows[i].adr, rows[i].wr);
            wb(1'b0, rows[i].adr, 32'h0000_0000);
            chk(rows[i].rd, q);
        end
        chk({29'h0, level}, 32'h0000_0005);
        chk({29'h0, blevel}, 32'h0000_0006);
        // Channel 3 compare, channel 6 capture with edge code left at reset (none), then enable both
        wb(1'b1, 8'h00, 32'h0000_0040);
        wb(1'b1, 8'h4C, 32'h0000_0100);
        wb(1'b1, 8'h2C, 32'h0000_0000);
        wb(1'b1, 8'h08, 32'h0000_0048);
        wb(1'b1, 8'h0C, 32'h0000_0000);
        wb(1'b1, 8'h04, 32'h0000_0048);
        match();
        chk({31'h0, irq}, 32'h0000_0001);
        @(posedge clk_i) auto <= 1'b1;
        wait_low();
        chk({31'h0, irq}, 32'h0000_0000);
        wb(1'b0, 8'h0C, 32'h0000_0000);
        chk(q, 32'h0000_0008);
        match();
        chk({31'h0, irq}, 32'h0000_0000);
        wb(1'b1, 8'h0C, 32'h0000_00F7);
        wb(1'b0, 8'h0C, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        wb(1'b1, 8'h08, 32'h0000_0040);
        match();
        chk({31'h0, irq}, 32'h0000_0000);
        wb(1'b0, 8'h0C, 32'h0000_0000);
        chk(q, 32'h0000_0008);
        wb(1'b1, 8'h08, 32'h0000_0048);
        // Base timer reset and overflow
        @(posedge clk_i) breset <= 1'b1;
        @(posedge clk_i) breset <= 1'b0;
        #1 chk({31'h0, birq}, 32'h0000_0001);
        wait_low();
        @(posedge clk_i) bovf <= 1'b1;
        @(posedge clk_i) bovf <= 1'b0;
        #1 chk({31'h0, birq}, 32'h0000_0001);
        wait_low();
        // Every capture edge code on channel 6
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, 8'h38, {30'h0, 2'(c)});
            wb(1'b1, 8'h0C, 32'h0000_0000);
            @(posedge clk_i) pin <= 8'h40;
            repeat (8) @(posedge clk_i);
            wb(1'b0, 8'h0C, 32'h0000_0000);
            r = q[6];
            wb(1'b1, 8'h0C, 32'h0000_0000);
            @(posedge clk_i) pin <= 8'h00;
            repeat (8) @(posedge clk_i);
            wb(1'b0, 8'h0C, 32'h0000_0000);
            chk({30'h0, q[6], r}, {30'h0, 2'(c)});
        end
        // Idle channel 0 shows start level, then its complement
        wb(1'b1, 8'h20, 32'h0000_0040);
        repeat (3) @(posedge clk_i);
        chk({31'h0, wave[0]}, 32'h0000_0001);
        wb(1'b1, 8'h20, 32'h0000_1040);
        repeat (3) @(posedge clk_i);
        chk({31'h0, wave[0]}, 32'h0000_0000);
        end_of_test();
    end
endmodule
